//--- core/bcs_cfg.svh
`ifndef BCS_CFG_SVH
`define BCS_CFG_SVH

// Clock rate and timer base
`define BCS_CLK_MHZ 100
`define BCS_TICK_MS 100

// Typical timeouts with 1 nF on both timing caps, in minutes
`define BCS_PREQ_MIN 7.5
`define BCS_FAST_MIN 90.0
`define BCS_FULL_MIN 90.0
`define BCS_TOPOFF_MIN 45.0

// Timer counter width
`define BCS_TMR_W 32

`endif

//--- core/bcs_pkg.sv
package bcs_pkg;

	// One-hot charger states
	typedef enum logic [6:0] {
		BCS_RESET  = 7'h01,
		BCS_PREQ   = 7'h02,
		BCS_FAST   = 7'h04,
		BCS_FULL   = 7'h08,
		BCS_TOPOFF = 7'h10,
		BCS_DONE   = 7'h20,
		BCS_FAULT  = 7'h40
	} bcs_state_e;

	// Command to the power stage
	typedef enum logic [1:0] {
		BCS_CMD_OFF = 2'h0,
		BCS_CMD_PRE = 2'h1,
		BCS_CMD_CC  = 2'h2,
		BCS_CMD_CV  = 2'h3
	} bcs_cmd_e;

endpackage : bcs_pkg

//--- core/bcs_tick_div.sv
module bcs_tick_div #(
	parameter int unsigned CYCLES = 10000000
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Tick output
	output logic tick
);

	logic [31:0] cnt_ff;
	logic tick_ff;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 32'h0000_0000;
			tick_ff <= 1'b0;
		end else if (cnt_ff == 32'(CYCLES - 1)) begin
			cnt_ff <= 32'h0000_0000;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 32'h0000_0001;
			tick_ff <= 1'b0;
		end
	end

	assign tick = tick_ff;

endmodule : bcs_tick_div

//--- core/bcs_timeout.sv
`include "bcs_cfg.svh"

module bcs_timeout #(
	parameter int W = `BCS_TMR_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Control
	input wire logic clear,
	input wire logic tickEn,
	input wire logic [W-1:0] limit,
	// Status
	output logic [W-1:0] count,
	output logic expired
);

	logic [W-1:0] count_ff;
	logic expired_ff;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_ff <= '0;
		end else if (clear) begin
			count_ff <= '0;
		end else if (tickEn && count_ff < limit) begin
			count_ff <= count_ff + W'(1);
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			expired_ff <= 1'b0;
		end else begin
			expired_ff <= !clear && (count_ff >= limit);
		end
	end

	assign count = count_ff;
	assign expired = expired_ff;

endmodule : bcs_timeout

//--- core/bcs_charge_fsm.sv
`include "bcs_cfg.svh"

module bcs_charge_fsm #(
	parameter int unsigned PRI_TICK_CYCLES = `BCS_TICK_MS * 1000 * `BCS_CLK_MHZ,
	parameter int unsigned SEC_TICK_CYCLES = `BCS_TICK_MS * 1000 * `BCS_CLK_MHZ,
	parameter int unsigned PREQ_TICKS = int'(`BCS_PREQ_MIN * 60000.0 / `BCS_TICK_MS),
	parameter int unsigned FAST_TICKS = int'(`BCS_FAST_MIN * 60000.0 / `BCS_TICK_MS),
	parameter int unsigned FULL_TICKS = int'(`BCS_FULL_MIN * 60000.0 / `BCS_TICK_MS),
	parameter int unsigned TOPOFF_TICKS = int'(`BCS_TOPOFF_MIN * 60000.0 / `BCS_TICK_MS)
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// External enable
	input wire logic charge_disable_n,
	// Analog comparator results
	input wire logic battAboveUv,
	input wire logic battAtReg,
	input wire logic currentBelowTenPct,
	input wire logic tempInRange,
	input wire logic supplyHeadroomOk,
	input wire logic battOverVolt,
	input wire logic battBelowRecharge,
	// Power stage command
	output bcs_pkg::bcs_cmd_e chargeCmd,
	// Open-drain indicators, enable high while pulling low
	output logic faultOut,
	output logic faultOe,
	output logic const_current_indicator,
	output logic const_current_indicatorOe,
	output logic const_voltage_indicator,
	output logic const_voltage_indicatorOe,
	// State view
	output bcs_pkg::bcs_state_e chargeState
);

	localparam int TW = `BCS_TMR_W;

	////////////////////////////////////////////////////////////////////////////
	// Input sampling

	logic chgEnN_ff;
	logic aboveUv_ff;
	logic atReg_ff;
	logic lowCur_ff;
	logic tempOk_ff;
	logic headOk_ff;
	logic overVolt_ff;
	logic belowRchg_ff;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			chgEnN_ff <= 1'b0;
			aboveUv_ff <= 1'b0;
			atReg_ff <= 1'b0;
			lowCur_ff <= 1'b0;
			tempOk_ff <= 1'b0;
			headOk_ff <= 1'b0;
			overVolt_ff <= 1'b0;
			belowRchg_ff <= 1'b0;
		end else begin
			chgEnN_ff <= charge_disable_n;
			aboveUv_ff <= battAboveUv;
			atReg_ff <= battAtReg;
			lowCur_ff <= currentBelowTenPct;
			tempOk_ff <= tempInRange;
			headOk_ff <= supplyHeadroomOk;
			overVolt_ff <= battOverVolt;
			belowRchg_ff <= battBelowRecharge;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timers

	bcs_pkg::bcs_state_e state_ff;
	bcs_pkg::bcs_state_e nxt_state;
	logic priTick;
	logic secTick;
	logic timerClear;
	logic timerTick;
	logic timerExpired;
	logic [TW-1:0] timerCount;
	logic [TW-1:0] timerLimit;
	logic runOk;
	logic suspended;

	// Charging states are the ones the thermistor can pause
	function automatic logic isCharging(input bcs_pkg::bcs_state_e s);
		return s == bcs_pkg::BCS_PREQ || s == bcs_pkg::BCS_FAST ||
			s == bcs_pkg::BCS_FULL || s == bcs_pkg::BCS_TOPOFF;
	endfunction : isCharging

	// Any of these drops the charger straight back to reset
	assign runOk = chgEnN_ff && headOk_ff && !overVolt_ff;
	assign suspended = isCharging(state_ff) && !tempOk_ff;

	bcs_tick_div #(
		.CYCLES(PRI_TICK_CYCLES)
	) u_priDiv (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.tick(priTick)
	);

	bcs_tick_div #(
		.CYCLES(SEC_TICK_CYCLES)
	) u_secDiv (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.tick(secTick)
	);

	always_comb begin
		case (state_ff)
			bcs_pkg::BCS_PREQ: timerLimit = TW'(PREQ_TICKS);
			bcs_pkg::BCS_FAST: timerLimit = TW'(FAST_TICKS);
			bcs_pkg::BCS_FULL: timerLimit = TW'(FULL_TICKS);
			bcs_pkg::BCS_TOPOFF: timerLimit = TW'(TOPOFF_TICKS);
			default: timerLimit = '1;
		endcase
	end

	// Fast charge alone runs off the secondary cap
	assign timerTick = isCharging(state_ff) && !suspended && runOk &&
		((state_ff == bcs_pkg::BCS_FAST) ? secTick : priTick);
	// Fresh count on every state change; held at zero in reset
	assign timerClear = (nxt_state != state_ff) || state_ff == bcs_pkg::BCS_RESET;

	bcs_timeout #(
		.W(TW)
	) u_timer (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.clear(timerClear),
		.tickEn(timerTick),
		.limit(timerLimit),
		.count(timerCount),
		.expired(timerExpired)
	);

	////////////////////////////////////////////////////////////////////////////
	// State machine

	always_comb begin
		nxt_state = state_ff;
		if (!runOk) begin
			nxt_state = bcs_pkg::BCS_RESET;
		end else if (suspended) begin
			nxt_state = state_ff;
		end else begin
			case (state_ff)
				bcs_pkg::BCS_RESET: begin
					nxt_state = bcs_pkg::BCS_PREQ;
				end
				bcs_pkg::BCS_PREQ: begin
					if (aboveUv_ff) begin
						nxt_state = bcs_pkg::BCS_FAST;
					end else if (timerExpired) begin
						nxt_state = bcs_pkg::BCS_FAULT;
					end
				end
				bcs_pkg::BCS_FAST: begin
					if (atReg_ff) begin
						nxt_state = bcs_pkg::BCS_FULL;
					end else if (timerExpired) begin
						nxt_state = bcs_pkg::BCS_FAULT;
					end else if (!aboveUv_ff) begin
						nxt_state = bcs_pkg::BCS_PREQ;
					end
				end
				bcs_pkg::BCS_FULL: begin
					if (lowCur_ff || timerExpired) begin
						nxt_state = bcs_pkg::BCS_TOPOFF;
					end
				end
				bcs_pkg::BCS_TOPOFF: begin
					if (timerExpired) begin
						nxt_state = bcs_pkg::BCS_DONE;
					end
				end
				bcs_pkg::BCS_DONE: begin
					if (belowRchg_ff) begin
						nxt_state = bcs_pkg::BCS_RESET;
					end
				end
				bcs_pkg::BCS_FAULT: begin
					nxt_state = bcs_pkg::BCS_FAULT;
				end
				default: begin
					nxt_state = bcs_pkg::BCS_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= bcs_pkg::BCS_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	bcs_pkg::bcs_cmd_e cmd_ff;
	logic faultOe_ff;
	logic ccOe_ff;
	logic cvOe_ff;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_ff <= bcs_pkg::BCS_CMD_OFF;
		end else if (!runOk || suspended) begin
			cmd_ff <= bcs_pkg::BCS_CMD_OFF;
		end else begin
			case (state_ff)
				bcs_pkg::BCS_PREQ: cmd_ff <= bcs_pkg::BCS_CMD_PRE;
				bcs_pkg::BCS_FAST: cmd_ff <= bcs_pkg::BCS_CMD_CC;
				bcs_pkg::BCS_FULL: cmd_ff <= bcs_pkg::BCS_CMD_CV;
				bcs_pkg::BCS_TOPOFF: cmd_ff <= bcs_pkg::BCS_CMD_CV;
				default: cmd_ff <= bcs_pkg::BCS_CMD_OFF;
			endcase
		end
	end

	// Indicators follow the state, so a pause leaves them as they were
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			faultOe_ff <= 1'b0;
			ccOe_ff <= 1'b0;
			cvOe_ff <= 1'b0;
		end else begin
			faultOe_ff <= state_ff == bcs_pkg::BCS_FAULT;
			ccOe_ff <= state_ff == bcs_pkg::BCS_PREQ ||
				state_ff == bcs_pkg::BCS_FAST;
			cvOe_ff <= state_ff == bcs_pkg::BCS_FULL;
		end
	end

	assign chargeCmd = cmd_ff;
	assign faultOut = 1'b0;
	assign faultOe = faultOe_ff;
	assign const_current_indicator = 1'b0;
	assign const_current_indicatorOe = ccOe_ff;
	assign const_voltage_indicator = 1'b0;
	assign const_voltage_indicatorOe = cvOe_ff;
	assign chargeState = state_ff;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	sequence sTopoffEnd;
		state_ff == bcs_pkg::BCS_TOPOFF && timerExpired && runOk && tempOk_ff;
	endsequence

	sequence sDoneOff;
		state_ff == bcs_pkg::BCS_DONE ##1 cmd_ff == bcs_pkg::BCS_CMD_OFF;
	endsequence

	a_reset_clears_timer: assert property (
		state_ff == bcs_pkg::BCS_RESET |-> timerCount == '0 ##1 !timerExpired)
		else $error("timer not cleared in reset");

	a_reset_to_preq: assert property (
		state_ff == bcs_pkg::BCS_RESET && runOk |=> state_ff == bcs_pkg::BCS_PREQ)
		else $error("reset did not advance to prequal");

	a_preq_cmd_level: assert property (
		state_ff == bcs_pkg::BCS_PREQ && runOk && tempOk_ff |=>
		cmd_ff == bcs_pkg::BCS_CMD_PRE)
		else $error("prequal current wrong");

	a_preq_to_fast: assert property (
		state_ff == bcs_pkg::BCS_PREQ && runOk && tempOk_ff && aboveUv_ff |=>
		state_ff == bcs_pkg::BCS_FAST ##1 ccOe_ff && cmd_ff == bcs_pkg::BCS_CMD_CC)
		else $error("prequal to fast failed");

	a_preq_timeout: assert property (
		state_ff == bcs_pkg::BCS_PREQ && runOk && tempOk_ff && !aboveUv_ff &&
		timerExpired |=> state_ff == bcs_pkg::BCS_FAULT ##1 faultOe_ff)
		else $error("prequal timeout fault missing");

	a_temp_freeze: assert property (
		suspended && runOk |=> $stable(timerCount) && $stable(state_ff))
		else $error("timer or state moved while paused");

	a_susp_quiet: assert property (
		suspended && runOk |=> cmd_ff == bcs_pkg::BCS_CMD_OFF &&
		$stable(ccOe_ff) && $stable(cvOe_ff) && $stable(faultOe_ff))
		else $error("pause changed output");

	a_fast_to_full: assert property (
		state_ff == bcs_pkg::BCS_FAST && runOk && tempOk_ff && atReg_ff |=>
		state_ff == bcs_pkg::BCS_FULL ##1 cvOe_ff && !ccOe_ff)
		else $error("fast to full failed");

	a_fast_timeout: assert property (
		state_ff == bcs_pkg::BCS_FAST && runOk && tempOk_ff && !atReg_ff &&
		timerExpired |=> state_ff == bcs_pkg::BCS_FAULT)
		else $error("fast timeout fault missing");

	a_full_cmd: assert property (
		state_ff == bcs_pkg::BCS_FULL && runOk && tempOk_ff |=>
		cmd_ff == bcs_pkg::BCS_CMD_CV && cvOe_ff)
		else $error("full charge outputs wrong");

	a_full_exit: assert property (
		state_ff == bcs_pkg::BCS_FULL && runOk && tempOk_ff &&
		(lowCur_ff || timerExpired) |=> state_ff == bcs_pkg::BCS_TOPOFF)
		else $error("full to top-off failed");

	a_topoff_done: assert property (
		sTopoffEnd |=> sDoneOff)
		else $error("top-off end wrong");

	a_done_recharge: assert property (
		state_ff == bcs_pkg::BCS_DONE && runOk && belowRchg_ff |=>
		state_ff == bcs_pkg::BCS_RESET)
		else $error("recharge restart missing");

	a_disable_stops: assert property (
		!charge_disable_n |=> ##1 state_ff == bcs_pkg::BCS_RESET &&
		cmd_ff == bcs_pkg::BCS_CMD_OFF)
		else $error("disable did not stop charge");

	a_fault_pin: assert property (
		faultOe_ff |-> $past(state_ff) == bcs_pkg::BCS_FAULT)
		else $error("fault pin low without fault");

	a_force_reset: assert property (
		!headOk_ff || overVolt_ff |=> state_ff == bcs_pkg::BCS_RESET)
		else $error("no forced reset");

	a_release_idle: assert property (
		state_ff == bcs_pkg::BCS_DONE |=> !ccOe_ff && !cvOe_ff && !faultOe_ff)
		else $error("indicator active in done");

endmodule : bcs_charge_fsm

//--- verif/bcs_partner.sv
////////////////////////////////////////////////////////////////////////////////
// Behavioural battery and comparator bank: level rises while the stage sources
// current, and the taper flag asserts after a stretch of constant voltage.
module bcs_partner #(
	parameter int UV_LVL = 20,
	parameter int REG_LVL = 60,
	parameter int RCH_LVL = 50,
	parameter int TAPER_CYC = 10
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Stage command
	input wire bcs_pkg::bcs_cmd_e chargeCmd,
	// Bench control
	input wire logic lvlLoad,
	input wire logic [7:0] lvlVal,
	input wire logic [7:0] lvlCap,
	input wire logic taperOn,
	// Comparator results
	output logic battAboveUv,
	output logic battAtReg,
	output logic currentBelowTenPct,
	output logic battBelowRecharge
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] level_ff;
	logic [7:0] cvCnt_ff;
	logic sourcing;

	assign sourcing = (chargeCmd == bcs_pkg::BCS_CMD_PRE) || (chargeCmd == bcs_pkg::BCS_CMD_CC);

	// Cap lets a scenario hold the cell below a threshold on purpose
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			level_ff <= 8'h00;
		end else if (lvlLoad) begin
			level_ff <= lvlVal;
		end else if (sourcing && level_ff < lvlCap) begin
			level_ff <= level_ff + 8'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cvCnt_ff <= 8'h00;
		end else if (chargeCmd != bcs_pkg::BCS_CMD_CV) begin
			cvCnt_ff <= 8'h00;
		end else if (cvCnt_ff < 8'(TAPER_CYC)) begin
			cvCnt_ff <= cvCnt_ff + 8'h01;
		end
	end

	assign battAboveUv = level_ff > 8'(UV_LVL);
	assign battAtReg = level_ff >= 8'(REG_LVL);
	assign battBelowRecharge = level_ff < 8'(RCH_LVL);
	assign currentBelowTenPct = taperOn && (cvCnt_ff >= 8'(TAPER_CYC));
endmodule : bcs_partner

//--- verif/battery_charge_state_machine_tb.sv
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("MISMATCH t=%0t %s", $time, msg); end end

module battery_charge_state_machine_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk, arst_n, charge_disable_n, tempInRange, supplyHeadroomOk, battOverVolt;
	logic lvlLoad, taperOn;
	logic [7:0] lvlVal, lvlCap;
	logic battAboveUv, battAtReg, currentBelowTenPct, battBelowRecharge;
	logic faultOut, faultOe, ccOut, ccOe, cvOut, cvOe;
	bcs_pkg::bcs_cmd_e chargeCmd;
	bcs_pkg::bcs_state_e chargeState, prevState, pendState;
	bcs_pkg::bcs_state_e expQ[$];
	logic pend;
	int fail_count, n_checks;
	// Dwell of the state just left, in clock cycles
	time chgTime = 0;
	int dwell;
	// Pull-ups on the open-drain indicator pins
	wire faultPin = faultOe ? faultOut : 1'b1;
	wire ccPin = ccOe ? ccOut : 1'b1;
	wire cvPin = cvOe ? cvOut : 1'b1;

	// Short ticks and limits so every timeout fits in a few hundred cycles
	localparam int TICK_CYC = 4;
	localparam int PREQ_T = 10;
	localparam int FAST_T = 20;
	localparam int FULL_T = 15;
	localparam int TOPOFF_T = 8;

	bcs_charge_fsm #(.PRI_TICK_CYCLES(TICK_CYC), .SEC_TICK_CYCLES(TICK_CYC),
		.PREQ_TICKS(PREQ_T), .FAST_TICKS(FAST_T), .FULL_TICKS(FULL_T),
		.TOPOFF_TICKS(TOPOFF_T)) u_dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .charge_disable_n(charge_disable_n),
		.battAboveUv(battAboveUv), .battAtReg(battAtReg),
		.currentBelowTenPct(currentBelowTenPct), .tempInRange(tempInRange),
		.supplyHeadroomOk(supplyHeadroomOk), .battOverVolt(battOverVolt),
		.battBelowRecharge(battBelowRecharge), .chargeCmd(chargeCmd),
		.faultOut(faultOut), .faultOe(faultOe), .const_current_indicator(ccOut),
		.const_current_indicatorOe(ccOe), .const_voltage_indicator(cvOut),
		.const_voltage_indicatorOe(cvOe), .chargeState(chargeState));

	bcs_partner u_partner (.sys_clk(sys_clk), .arst_n(arst_n), .chargeCmd(chargeCmd),
		.lvlLoad(lvlLoad), .lvlVal(lvlVal), .lvlCap(lvlCap), .taperOn(taperOn),
		.battAboveUv(battAboveUv), .battAtReg(battAtReg),
		.currentBelowTenPct(currentBelowTenPct), .battBelowRecharge(battBelowRecharge));

	always #5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////////
	// Command and pins {fault, cc, cv} expected in each state
	function automatic logic [4:0] expOut(bcs_pkg::bcs_state_e s);
		case (s)
			bcs_pkg::BCS_PREQ: return {bcs_pkg::BCS_CMD_PRE, 3'h5};
			bcs_pkg::BCS_FAST: return {bcs_pkg::BCS_CMD_CC, 3'h5};
			bcs_pkg::BCS_FULL: return {bcs_pkg::BCS_CMD_CV, 3'h6};
			bcs_pkg::BCS_TOPOFF: return {bcs_pkg::BCS_CMD_CV, 3'h7};
			bcs_pkg::BCS_FAULT: return {bcs_pkg::BCS_CMD_OFF, 3'h3};
			default: return {bcs_pkg::BCS_CMD_OFF, 3'h7};
		endcase
	endfunction : expOut

	// Watcher: every state change takes the oldest note; outputs are checked an edge later
	always @(negedge sys_clk) begin
		if (pend && chargeState === pendState) begin
			`CHK({chargeCmd, faultPin, ccPin, cvPin}, expOut(pendState), "outputs vs state")
		end
		pend = 1'b0;
		if (arst_n && chargeState !== prevState) begin
			if (expQ.size() == 0) begin
				`CHK(chargeState, prevState, "unexpected state change")
			end else begin
				`CHK(chargeState, expQ.pop_front(), "state order")
			end
			pend = 1'b1;
			pendState = chargeState;
			prevState = chargeState;
			dwell = int'(($time - chgTime) / 10);
			chgTime = $time;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	task automatic waitState(bcs_pkg::bcs_state_e s);
		for (int i = 0; i < 600 && chargeState !== s; i++) @(posedge sys_clk);
		if (chargeState !== s) begin
			fail_count++;
			$display("MISMATCH t=%0t state wait timed out", $time);
			print_verdict();
		end else begin
			cyc(3);
		end
	endtask : waitState

	task automatic load(logic [7:0] lvl, logic [7:0] cap, logic taper);
		@(posedge sys_clk);
		lvlLoad <= 1'b1;
		lvlVal <= lvl;
		lvlCap <= cap;
		taperOn <= taper;
		@(posedge sys_clk);
		lvlLoad <= 1'b0;
	endtask : load

	// Disable low parks the charger in reset
	task automatic park();
		expQ.push_back(bcs_pkg::BCS_RESET);
		@(posedge sys_clk);
		charge_disable_n <= 1'b0;
		waitState(bcs_pkg::BCS_RESET);
		`CHK(chargeCmd, bcs_pkg::BCS_CMD_OFF, "no charge while disabled")
	endtask : park

	task automatic endTest(string name);
		`CHK(expQ.size() == 0, 1'b1, "states left unseen")
		$display("Test %s finished, mismatches so far %0d", name, fail_count);
	endtask : endTest

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		arst_n = 1'b0;
		charge_disable_n = 1'b0;
		tempInRange = 1'b1;
		supplyHeadroomOk = 1'b1;
		battOverVolt = 1'b0;
		{lvlLoad, taperOn, lvlVal, lvlCap} = '0;
		prevState = bcs_pkg::BCS_RESET;
		pend = 1'b0;
		void'($urandom(45));
		cyc(12);
		arst_n <= 1'b1;
		// Full cycle with taper-driven top-off
		load(8'h00, 8'h64, 1'b1);
		expQ = '{bcs_pkg::BCS_PREQ, bcs_pkg::BCS_FAST, bcs_pkg::BCS_FULL,
			bcs_pkg::BCS_TOPOFF, bcs_pkg::BCS_DONE};
		@(posedge sys_clk);
		charge_disable_n <= 1'b1;
		waitState(bcs_pkg::BCS_DONE);
		cyc(20);
		`CHK(chargeState, bcs_pkg::BCS_DONE, "done holds")
		endTest("full_cycle");
		// Recharge, top-off by full-charge timer, then a random reset cause
		expQ = '{bcs_pkg::BCS_RESET, bcs_pkg::BCS_PREQ, bcs_pkg::BCS_FAST,
			bcs_pkg::BCS_FULL, bcs_pkg::BCS_TOPOFF};
		load(8'h2D, 8'h64, 1'b0);
		waitState(bcs_pkg::BCS_TOPOFF);
		expQ.push_back(bcs_pkg::BCS_RESET);
		@(posedge sys_clk);
		if ($urandom_range(1, 0) != 0) battOverVolt <= 1'b1;
		else supplyHeadroomOk <= 1'b0;
		waitState(bcs_pkg::BCS_RESET);
		cyc(10);
		`CHK(chargeState, bcs_pkg::BCS_RESET, "forced reset holds")
		@(posedge sys_clk);
		battOverVolt <= 1'b0;
		supplyHeadroomOk <= 1'b1;
		charge_disable_n <= 1'b0;
		endTest("recharge_forced_reset");
		// Cell stuck below undervoltage: prequal timeout
		load(8'h00, 8'h0A, 1'b1);
		expQ = '{bcs_pkg::BCS_PREQ, bcs_pkg::BCS_FAULT};
		@(posedge sys_clk);
		charge_disable_n <= 1'b1;
		waitState(bcs_pkg::BCS_FAULT);
		// Limit ticks plus up to one divider phase and the two-edge expiry path
		`CHK(dwell inside {[PREQ_T * TICK_CYC - 1 : PREQ_T * TICK_CYC + 2]}, 1'b1, "prequal time")
		cyc(30);
		`CHK(chargeState, bcs_pkg::BCS_FAULT, "fault holds")
		park();
		endTest("prequal_timeout");
		// Temperature pause longer than the fast timer, then fast timeout
		load(8'h00, 8'h28, 1'b1);
		expQ = '{bcs_pkg::BCS_PREQ, bcs_pkg::BCS_FAST};
		@(posedge sys_clk);
		charge_disable_n <= 1'b1;
		waitState(bcs_pkg::BCS_FAST);
		@(posedge sys_clk);
		tempInRange <= 1'b0;
		cyc(5);
		`CHK(chargeCmd, bcs_pkg::BCS_CMD_OFF, "paused current")
		`CHK({faultPin, ccPin, cvPin}, 3'h5, "paused pins")
		cyc($urandom_range(200, 150));
		`CHK(chargeState, bcs_pkg::BCS_FAST, "timer frozen")
		expQ.push_back(bcs_pkg::BCS_FAULT);
		@(posedge sys_clk);
		tempInRange <= 1'b1;
		waitState(bcs_pkg::BCS_FAULT);
		park();
		endTest("pause_fast_timeout");
		print_verdict();
	end
endmodule : battery_charge_state_machine_tb
